// >>> design/alzm_param_hold.sv
`timescale 1ns/10ps
`default_nettype none
// snapshot register set: captured once at restart
module alzm_param_hold #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// capture
	input  wire logic         load,
	input  wire logic [W-1:0] d,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] q
);
	logic         loaded_ff;
	logic [W-1:0] q_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			loaded_ff <= 1'b0;
			q_ff      <= '0;
		end else if (load) begin
			loaded_ff <= 1'b1;
			q_ff      <= d;
		end
	end
	// until first capture the default value is shown
	assign q = loaded_ff ? q_ff : rst_val;
endmodule
`default_nettype wire

// >>> design/alzm_pkg.sv
//------------------------------------------------------------
// Operation
// (RQ1) zone output high while position lies between lower and upper bound
// (RQ2) zone output driven only for io pattern 0, 4 or 5
// (RQ3) second zone bound pair accepted but never compared
// (RQ4) positive and negative soft limits held, 0.01 mm units
// (RQ5) soft-limit-over error when position leaves soft-limit range
// (RQ6) error suppressed until position passes a limit by more than margin
// (RQ7) software places soft limits 0.3 mm outside effective travel
// (RQ8) parameters applied only at restart; software restarts after each change
// (RQ9) home direction from setting, reversal refused for rod actuators
// (RQ10) home position shifted by home offset from mechanical end
// (RQ11) move commands level-sensitive at 0, edge-triggered at 1
// (RQ12) completion output is positioning complete at 0, in position at 1
// (RQ13) home-return input honoured at 0, ignored at 1
// (RQ14) operating-mode input honoured at 0, ignored at 1
// (RQ15) enable function used only at 0, default 1 disables
// (RQ16) home check sensor normally open at 0, normally closed at 1
// (RQ17) speed override percent held, default 100
// (RQ18) three servo-off delays in seconds held, default 0
// (RQ19) load judgment time in ms held, default 0
// (RQ20) torque check range performed at 0, skipped at 1
// (RQ21) standstill mode defaults to 0, power saving disabled
// (RQ22) actual speed is table speed times override divided by 100
// (RQ23) standstill mode 1..3 selects servo-off delay 1..3
// (RQ24) compare once per control cycle, boundaries count as inside
// (RQ25) soft-limit error latched until reset and blocks motion
//------------------------------------------------------------
package alzm_pkg;
	localparam int          POS_W        = 32;
	localparam int          SPD_W        = 16;
	localparam int          DLY_W        = 16;
	localparam logic [3:0]  PAT_STANDARD = 4'h0;
	localparam logic [3:0]  PAT_SEVEN    = 4'h4;
	localparam logic [3:0]  PAT_THREE    = 4'h5;
	localparam logic [7:0]  OVR_RST      = 8'h64;
	localparam logic [7:0]  OVR_DIV      = 8'h64;
	localparam logic [15:0] DLY_RST      = 16'h0000;
	localparam logic [1:0]  STILL_RST    = 2'h0;
	localparam logic        ENABLE_FUNCTION_SELECT_RST     = 1'b1;
	localparam real         CLK_MHZ      = 125.0;
	localparam real         CTRL_US      = 1.0;
	localparam int          CTRL_CYC     = int'(CTRL_US * CLK_MHZ);
	localparam real         MS_US        = 1000.0;
	localparam int          MS_CYC       = int'(MS_US * CLK_MHZ);
	localparam int          SEC_MS       = 1000;
	typedef enum logic [1:0] {
		ALZM_ST_BOOT = 2'b00,
		ALZM_ST_RUN  = 2'b01,
		ALZM_ST_ERR  = 2'b10
	} alzm_state_t;
endpackage

// >>> design/alzm_top.sv
`timescale 1ns/10ps
`default_nettype none
module alzm_top #(
	parameter int POS_W    = alzm_pkg::POS_W,
	parameter int CTRL_CYC = alzm_pkg::CTRL_CYC,
	parameter int MS_CYC   = alzm_pkg::MS_CYC
) (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	// restart request (software reset)
	input  wire logic                    restart,
	// position feedback
	input  wire logic signed [POS_W-1:0] cur_pos,
	input  wire logic                    pos_done,
	input  wire logic                    pos_in_band,
	// zone settings
	input  wire logic signed [POS_W-1:0] zone_upper_bound,
	input  wire logic signed [POS_W-1:0] zone_lower_bound,
	input  wire logic signed [POS_W-1:0] zone2_upper_bound,
	input  wire logic signed [POS_W-1:0] zone2_lower_bound,
	input  wire logic [3:0]              io_pattern_select,
	// limit settings
	input  wire logic signed [POS_W-1:0] soft_limit_pos,
	input  wire logic signed [POS_W-1:0] soft_limit_neg,
	input  wire logic [POS_W-2:0]        limit_tolerance_margin,
	// home settings
	input  wire logic                    home_direction,
	input  wire logic                    rod_actuator,
	input  wire logic signed [POS_W-1:0] home_offset,
	input  wire logic                    home_check_polarity,
	// interface settings
	input  wire logic                    io_function_select,
	input  wire logic                    complete_mode_select,
	input  wire logic                    home_input_disable,
	input  wire logic                    mode_input_disable,
	input  wire logic                    enable_function_select,
	input  wire logic [7:0]              speed_override_pct,
	input  wire logic [15:0]             servo_off_delay_1,
	input  wire logic [15:0]             servo_off_delay_2,
	input  wire logic [15:0]             servo_off_delay_3,
	input  wire logic [15:0]             load_judge_time,
	input  wire logic                    torque_check_select,
	input  wire logic [1:0]              standstill_mode_default,
	// controller inputs
	input  wire logic                    move_cmd,
	input  wire logic                    home_req_in,
	input  wire logic                    op_mode_in,
	input  wire logic                    enable_in,
	input  wire logic                    home_sensor_in,
	input  wire logic [15:0]             table_speed,
	// outputs
	output logic                         zone_output,
	output logic                         soft_limit_err,
	output logic                         move_go,
	output logic                         completion_out,
	output logic                         home_go,
	output logic                         home_dir_out,
	output logic signed [POS_W-1:0]      home_pos_out,
	output logic                         op_mode_out,
	output logic                         enable_ok,
	output logic                         home_sensed,
	output logic                         torque_check_on,
	output logic [15:0]                  actual_speed,
	output logic                         servo_off,
	output logic [15:0]                  load_judge_ms
);
	localparam int PW = 5 * POS_W + 4 + 8 + 2 + 10;
	//------------------------------------------------------------
	// parameter capture
	//------------------------------------------------------------
	alzm_pkg::alzm_state_t st_ff;
	logic        cap;
	logic [PW-1:0] live, held, dflt;
	logic signed [POS_W-1:0] zu, zl, lp, ln, ho;
	logic [3:0]  pat;
	logic [7:0]  ovr;
	logic [1:0]  still;
	logic        hdir, cmd_edge, cmpl_sel, hdis, mdis, ensel, hpol, tsel, rod;
	logic [47:0] dly_live, dly_held;
	logic [POS_W-2:0] marg_held;
	logic [15:0] ldj;

	assign cap = (st_ff == alzm_pkg::ALZM_ST_BOOT); // RQ8
	// RQ3: second zone pair intentionally not captured
	assign live = {zone_upper_bound, zone_lower_bound, soft_limit_pos, soft_limit_neg, home_offset,
		io_pattern_select, speed_override_pct, standstill_mode_default, home_direction,
		io_function_select, complete_mode_select, home_input_disable, mode_input_disable,
		enable_function_select, home_check_polarity, torque_check_select, rod_actuator, 1'b0};
	assign dflt = {{(5*POS_W){1'b0}}, alzm_pkg::PAT_STANDARD, alzm_pkg::OVR_RST, alzm_pkg::STILL_RST,
		1'b0, 1'b0, 1'b0, 1'b0, 1'b0, alzm_pkg::ENABLE_FUNCTION_SELECT_RST, 1'b0, 1'b0, 1'b0, 1'b0};
	alzm_param_hold #(.W(PW)) u_set (
		.core_clk(core_clk), .rst_b(rst_b), .load(cap), .d(live), .rst_val(dflt), .q(held)
	); // RQ4
	assign dly_live = {servo_off_delay_1, servo_off_delay_2, servo_off_delay_3};
	alzm_param_hold #(.W(48)) u_dly (
		.core_clk(core_clk), .rst_b(rst_b), .load(cap), .d(dly_live),
		.rst_val({3{alzm_pkg::DLY_RST}}), .q(dly_held)
	); // RQ18
	alzm_param_hold #(.W(POS_W-1)) u_mrg (
		.core_clk(core_clk), .rst_b(rst_b), .load(cap), .d(limit_tolerance_margin),
		.rst_val('0), .q(marg_held)
	); // RQ6
	alzm_param_hold #(.W(16)) u_ldj (
		.core_clk(core_clk), .rst_b(rst_b), .load(cap), .d(load_judge_time),
		.rst_val(alzm_pkg::DLY_RST), .q(ldj)
	); // RQ19
	assign {zu, zl, lp, ln, ho, pat, ovr, still, hdir, cmd_edge, cmpl_sel, hdis, mdis,
		ensel, hpol, tsel, rod} = held[PW-1:1];

	//------------------------------------------------------------
	// state: boot captures, restart returns to boot
	//------------------------------------------------------------
	logic lim_over;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= alzm_pkg::ALZM_ST_BOOT;
		end else begin
			case (st_ff)
				alzm_pkg::ALZM_ST_BOOT: st_ff <= alzm_pkg::ALZM_ST_RUN;
				alzm_pkg::ALZM_ST_RUN: begin
					if (restart) st_ff <= alzm_pkg::ALZM_ST_BOOT; // RQ8
					else if (lim_over) st_ff <= alzm_pkg::ALZM_ST_ERR; // RQ25
				end
				alzm_pkg::ALZM_ST_ERR: if (restart) st_ff <= alzm_pkg::ALZM_ST_BOOT;
				default: st_ff <= alzm_pkg::ALZM_ST_BOOT;
			endcase
		end
	end

	//------------------------------------------------------------
	// control cycle tick and comparisons
	//------------------------------------------------------------
	logic [15:0] tick_ff;
	logic        tick;
	assign tick = (tick_ff == 16'(CTRL_CYC - 1));
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) tick_ff <= 16'h0000;
		else if (tick) tick_ff <= 16'h0000;
		else tick_ff <= tick_ff + 16'h0001;
	end

	logic signed [POS_W:0] lim_hi, lim_lo, pos_x;
	logic in_zone, pat_ok, zone_ff, err_ff;
	assign lim_hi = {lp[POS_W-1], lp} + {2'b00, marg_held}; // RQ6
	assign lim_lo = {ln[POS_W-1], ln} - {2'b00, marg_held};
	// a bare concatenation is unsigned; the signed copy keeps negative positions in order
	assign pos_x = {cur_pos[POS_W-1], cur_pos};
	assign lim_over = tick && ((pos_x > lim_hi) || (pos_x < lim_lo)); // RQ5 RQ24
	assign in_zone = (cur_pos >= zl) && (cur_pos <= zu); // RQ1 RQ24
	assign pat_ok = (pat == alzm_pkg::PAT_STANDARD) || (pat == alzm_pkg::PAT_SEVEN) ||
		(pat == alzm_pkg::PAT_THREE); // RQ2
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) zone_ff <= 1'b0;
		else if (tick) zone_ff <= in_zone && pat_ok && (st_ff != alzm_pkg::ALZM_ST_BOOT); // RQ1 RQ2
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) err_ff <= 1'b0;
		else if (st_ff == alzm_pkg::ALZM_ST_BOOT) err_ff <= 1'b0;
		else if (lim_over) err_ff <= 1'b1; // RQ25
	end
	assign zone_output    = zone_ff;
	assign soft_limit_err = err_ff;

	//------------------------------------------------------------
	// controller inputs
	//------------------------------------------------------------
	logic cmd_d_ff, go_ff, cmpl_ff, hgo_ff, hsens_ff, mode_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) cmd_d_ff <= 1'b0;
		else cmd_d_ff <= move_cmd;
	end
	// edge mode gives a one-cycle start pulse; level mode follows the input
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) go_ff <= 1'b0;
		else if (st_ff != alzm_pkg::ALZM_ST_RUN || enable_ok == 1'b0) go_ff <= 1'b0; // RQ25
		else go_ff <= cmd_edge ? (move_cmd && !cmd_d_ff) : move_cmd; // RQ11
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) cmpl_ff <= 1'b0;
		else cmpl_ff <= cmpl_sel ? pos_in_band : pos_done; // RQ12
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) hgo_ff <= 1'b0;
		else hgo_ff <= !hdis && home_req_in && (st_ff == alzm_pkg::ALZM_ST_RUN); // RQ13 RQ25
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) mode_ff <= 1'b0;
		else mode_ff <= mdis ? 1'b0 : op_mode_in; // RQ14
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) hsens_ff <= 1'b0;
		else hsens_ff <= hpol ? !home_sensor_in : home_sensor_in; // RQ16
	end
	assign move_go         = go_ff;
	assign completion_out  = cmpl_ff;
	assign home_go         = hgo_ff;
	assign op_mode_out     = mode_ff;
	assign home_sensed     = hsens_ff;
	assign enable_ok       = ensel ? 1'b1 : enable_in; // RQ15
	assign torque_check_on = !tsel; // RQ20
	// rod actuators keep the forward direction regardless of the setting
	assign home_dir_out    = rod ? 1'b0 : hdir; // RQ9
	assign home_pos_out    = ho; // RQ10
	assign load_judge_ms   = ldj;

	//------------------------------------------------------------
	// override speed
	//------------------------------------------------------------
	logic [23:0] spd_prod;
	logic [15:0] spd_ff;
	assign spd_prod = table_speed * ovr; // RQ17
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) spd_ff <= 16'h0000;
		else spd_ff <= 16'(spd_prod / 24'(alzm_pkg::OVR_DIV)); // RQ22
	end
	assign actual_speed = spd_ff;

	//------------------------------------------------------------
	// automatic servo-off timer
	//------------------------------------------------------------
	logic [15:0] dsel;
	logic [31:0] ms_ff;
	logic [31:0] ms_cnt_ff;
	logic        soff_ff;
	always_comb begin
		case (still) // RQ21 RQ23
			2'h1:    dsel = dly_held[47:32];
			2'h2:    dsel = dly_held[31:16];
			2'h3:    dsel = dly_held[15:0];
			default: dsel = 16'h0000;
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) ms_cnt_ff <= 32'h0;
		else if (!pos_done || ms_cnt_ff == 32'(MS_CYC - 1)) ms_cnt_ff <= 32'h0;
		else ms_cnt_ff <= ms_cnt_ff + 32'h1;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) ms_ff <= 32'h0;
		else if (!pos_done) ms_ff <= 32'h0;
		else if (ms_cnt_ff == 32'(MS_CYC - 1) && ms_ff != 32'hFFFFFFFF) ms_ff <= ms_ff + 32'h1;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) soff_ff <= 1'b0;
		else soff_ff <= pos_done && (still != 2'h0) &&
			(ms_ff >= 32'(dsel) * 32'(alzm_pkg::SEC_MS)); // RQ23
	end
	assign servo_off = soff_ff;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	// only the boot cycle after a restart may clear the error
	a_err_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
		err_ff && st_ff != alzm_pkg::ALZM_ST_BOOT |=> err_ff) else $error("limit error dropped"); // RQ25
	a_err_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		lim_over && st_ff == alzm_pkg::ALZM_ST_RUN |=> err_ff) else $error("limit error missed"); // RQ5
	a_err_nomove: assert property (@(posedge core_clk) disable iff (!rst_b)
		err_ff |=> !move_go) else $error("motion during error"); // RQ25
	a_zone_pat: assert property (@(posedge core_clk) disable iff (!rst_b)
		!pat_ok && tick |=> !zone_output) else $error("zone out with bad pattern"); // RQ2
	a_zone_in: assert property (@(posedge core_clk) disable iff (!rst_b)
		tick && in_zone && pat_ok && st_ff == alzm_pkg::ALZM_ST_RUN |=> zone_output)
		else $error("zone out missing"); // RQ1
	a_edge_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
		cmd_edge && move_go |=> !move_go) else $error("edge mode held"); // RQ11
	a_home_dis: assert property (@(posedge core_clk) disable iff (!rst_b)
		hdis |=> !home_go) else $error("home input not ignored"); // RQ13
	a_cmpl_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
		cmpl_sel && !$stable(cmpl_sel) == 1'b0 |=> completion_out == $past(pos_in_band))
		else $error("completion source wrong"); // RQ12
	a_cmpl_done: assert property (@(posedge core_clk) disable iff (!rst_b)
		!cmpl_sel |=> completion_out == $past(pos_done)) else $error("complete source wrong"); // RQ12
	a_enable_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		!enable_ok |=> !move_go) else $error("motion without enable"); // RQ15
	a_go_level: assert property (@(posedge core_clk) disable iff (!rst_b)
		!cmd_edge && st_ff == alzm_pkg::ALZM_ST_RUN && enable_ok && move_cmd |=> move_go)
		else $error("level command lost"); // RQ11
	a_home_go: assert property (@(posedge core_clk) disable iff (!rst_b)
		!hdis && home_req_in && st_ff == alzm_pkg::ALZM_ST_RUN |=> home_go) else $error("home input lost"); // RQ13
	a_mode_dis: assert property (@(posedge core_clk) disable iff (!rst_b)
		mdis |=> !op_mode_out) else $error("mode input not ignored"); // RQ14
	a_lim_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		tick && !lim_over && !err_ff && st_ff == alzm_pkg::ALZM_ST_RUN |=> !err_ff)
		else $error("limit error inside margin"); // RQ6
	a_err_boot: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_ff == alzm_pkg::ALZM_ST_BOOT |=> !soft_limit_err) else $error("error kept over restart"); // RQ8
	a_zone_boot: assert property (@(posedge core_clk) disable iff (!rst_b)
		st_ff == alzm_pkg::ALZM_ST_BOOT && tick |=> !zone_output) else $error("zone out during boot"); // RQ8
	a_still_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		still == 2'h0 |=> !servo_off) else $error("servo off while disabled"); // RQ21
	a_soff_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
		servo_off |-> $past(pos_done)) else $error("servo off before completion"); // RQ23

	//------------------------------------------------------------
	// coverage
	//------------------------------------------------------------
	c_zone: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(zone_output));
	c_err: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(soft_limit_err));
	c_soff: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(servo_off));
	c_pulse: cover property (@(posedge core_clk) disable iff (!rst_b) cmd_edge && $rose(move_go));
	c_home: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(home_go));
endmodule
`default_nettype wire

// >>> tb/alzm_plc_model.sv
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------
// controller side of the parallel i/o
//----------------------------------------
module alzm_plc_model (
	// clock
	input  wire logic   core_clk,
	// command lines
	output logic        move_cmd,
	output logic        home_req_in,
	output logic        op_mode_in,
	output logic        enable_in,
	output logic        home_sensor_in,
	output logic [15:0] table_speed
);
	initial begin
		{move_cmd, home_req_in, op_mode_in, enable_in, home_sensor_in, table_speed} = '0;
	end
	// lines move just after an edge, like a scanned controller output
	task automatic drive(input logic m, h, o, e, s, input logic [15:0] spd);
		@(posedge core_clk);
		move_cmd       <= m;
		home_req_in    <= h;
		op_mode_in     <= o;
		enable_in      <= e;
		home_sensor_in <= s;
		table_speed    <= spd;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int CC = 4;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic restart = 1'b0;
	logic pos_done = 1'b0;
	logic pos_in_band = 1'b0;
	logic signed [31:0] cur_pos = 32'h0000_0000;
	logic signed [31:0] zone_upper_bound = 32'h0000_1000, zone_lower_bound = 32'h0000_0800;
	logic signed [31:0] zone2_upper_bound = 32'h7FFF_FFFF, zone2_lower_bound = 32'h8000_0000;
	// limits sit 0.3 mm outside a 0..80 mm travel
	logic signed [31:0] soft_limit_pos = 32'h0000_1F5E, soft_limit_neg = 32'hFFFF_FFE2;
	logic signed [31:0] home_offset = 32'h0000_0000, home_pos_out;
	logic [30:0] limit_tolerance_margin = 31'h0000_000A;
	logic [3:0] io_pattern_select = 4'h0;
	logic [7:0] speed_override_pct = 8'h64;
	logic [15:0] servo_off_delay_1 = 16'h0000, servo_off_delay_2 = 16'h0000, servo_off_delay_3 = 16'h0000;
	logic [15:0] load_judge_time = 16'h0000, table_speed, actual_speed, load_judge_ms;
	logic [1:0] standstill_mode_default = 2'h0;
	logic home_direction = 1'b1, rod_actuator = 1'b0, home_check_polarity = 1'b0;
	logic io_function_select = 1'b0, complete_mode_select = 1'b0, home_input_disable = 1'b0;
	logic mode_input_disable = 1'b0, enable_function_select = 1'b1, torque_check_select = 1'b0;
	logic move_cmd, home_req_in, op_mode_in, enable_in, home_sensor_in;
	logic zone_output, soft_limit_err, move_go, completion_out, home_go, home_dir_out;
	logic op_mode_out, enable_ok, home_sensed, torque_check_on, servo_off;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	alzm_top #(.CTRL_CYC(CC), .MS_CYC(10)) i_dut (.*);
	alzm_plc_model i_plc (.*);

	initial begin
		forever #4 core_clk = ~core_clk;
	end
	//----------------------------------------
	// helpers
	//----------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// two control ticks plus pipeline slack
	task automatic settle;
		repeat (2 * CC + 4) @(posedge core_clk);
		#1;
	endtask
	task automatic do_restart;
		@(posedge core_clk) restart <= 1'b1;
		@(posedge core_clk) restart <= 1'b0;
		settle();
	endtask
	task automatic set_pos(input logic [31:0] p);
		@(posedge core_clk) cur_pos <= p;
		settle();
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic t_zone;
		logic [3:0] pats [5] = '{4'h0, 4'h4, 4'h5, 4'h1, 4'h2};
		logic [31:0] ps [5] = '{32'h0000_07FF, 32'h0000_0800, 32'h0000_0C00, 32'h0000_1000, 32'h0000_1001};
		for (int i = 0; i < 5; i++) begin
			@(posedge core_clk) io_pattern_select <= pats[i];
			do_restart();
			for (int j = 0; j < 5; j++) begin
				set_pos(ps[j]);
				chk("zone_output", i < 3 && j > 0 && j < 4, zone_output);
			end
		end
	endtask
	task automatic t_limit;
		@(posedge core_clk) io_pattern_select <= 4'h0;
		do_restart();
		set_pos(32'h0000_1F68);
		chk("soft_limit_err", 1'b0, soft_limit_err);
		set_pos(32'h0000_1F69);
		chk("soft_limit_err", 1'b1, soft_limit_err);
		set_pos(32'h0000_0100);
		i_plc.drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100);
		settle();
		chk("soft_limit_err", 1'b1, soft_limit_err);
		chk("move_go", 1'b0, move_go);
		i_plc.drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100);
		do_restart();
		chk("soft_limit_err", 1'b0, soft_limit_err);
		// a new limit without restart must stay unseen
		@(posedge core_clk) soft_limit_pos <= 32'h0000_0050;
		settle();
		chk("soft_limit_err", 1'b0, soft_limit_err);
		@(posedge core_clk) soft_limit_pos <= 32'h0000_1F5E;
		set_pos(32'hFFFF_FFD8);
		chk("soft_limit_err", 1'b0, soft_limit_err);
		set_pos(32'hFFFF_FFD7);
		chk("soft_limit_err", 1'b1, soft_limit_err);
		set_pos(32'h0000_0100);
		do_restart();
	endtask
	task automatic t_modes;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			complete_mode_select <= i[0];
			home_input_disable <= i[0];
			mode_input_disable <= i[0];
			home_check_polarity <= i[0];
			torque_check_select <= i[0];
			rod_actuator <= i[0];
			home_offset <= i ? 32'h0000_0100 : 32'h0000_0200;
			load_judge_time <= i ? 16'h0007 : 16'h0000;
			speed_override_pct <= i ? 8'h14 : 8'h64;
			pos_done <= 1'b1;
			do_restart();
			i_plc.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, i ? 16'h01F4 : 16'h04D2);
			settle();
			chk("completion_out", !i, completion_out);
			chk("home_go", !i, home_go);
			chk("op_mode_out", !i, op_mode_out);
			chk("home_sensed", i, home_sensed);
			chk("torque_check_on", !i, torque_check_on);
			chk("home_dir_out", !i, home_dir_out);
			chk("home_pos_out", i ? 32'h0000_0100 : 32'h0000_0200, home_pos_out);
			chk("actual_speed", i ? 32'h0000_0064 : 32'h0000_04D2, actual_speed);
			chk("load_judge_ms", i ? 32'h0000_0007 : 32'h0000_0000, load_judge_ms);
			chk("servo_off", 1'b0, servo_off);
		end
	endtask
	task automatic t_move;
		int n;
		@(posedge core_clk) enable_function_select <= 1'b0;
		do_restart();
		i_plc.drive(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0100);
		settle();
		chk("move_go", 1'b0, move_go);
		chk("enable_ok", 1'b0, enable_ok);
		i_plc.drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100);
		settle();
		chk("move_go", 1'b1, move_go);
		chk("enable_ok", 1'b1, enable_ok);
		i_plc.drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100);
		io_function_select <= 1'b1;
		enable_function_select <= 1'b1;
		do_restart();
		i_plc.drive(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0100);
		n = 0;
		repeat (12) begin
			@(posedge core_clk);
			#1;
			n += (move_go === 1'b1);
		end
		chk("move_go pulses", 32'h0000_0001, n);
	endtask
	// mode 2 picks delay 2 = 1 s = 1000 ms of 10 cycles each; delay 1 = 0 would fire at once
	task automatic t_soff;
		@(posedge core_clk);
		standstill_mode_default <= 2'h2;
		servo_off_delay_1 <= 16'h0000;
		servo_off_delay_2 <= 16'h0001;
		servo_off_delay_3 <= 16'h0000;
		pos_done <= 1'b0;
		do_restart();
		@(posedge core_clk) pos_done <= 1'b1;
		repeat (9980) @(posedge core_clk);
		#1;
		chk("servo_off early", 1'b0, servo_off);
		repeat (40) @(posedge core_clk);
		#1;
		chk("servo_off", 1'b1, servo_off);
	endtask
	//----------------------------------------
	// run
	//----------------------------------------
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("ERROR timeout expected done seen hang");
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		settle();
		t_zone();
		t_limit();
		t_modes();
		t_move();
		t_soff();
		print_verdict();
	end
endmodule
`default_nettype wire
